// *** hdl/smpc_pkg.sv ***
// package for the stop-mode power controller: modes, peripheral ids, structs
`default_nettype none
package smpc_pkg;
   // peripheral index layout for clock gates and wake resets
   localparam int SMPC_NUM_PERIPH = 8;
   localparam int SMPC_P_CLKGEN   = 0;
   localparam int SMPC_P_TIMER1   = 1;
   localparam int SMPC_P_TIMER2   = 2;
   localparam int SMPC_P_CONV     = 3;
   localparam int SMPC_P_KBD      = 4;
   localparam int SMPC_P_SERIAL1  = 5;
   localparam int SMPC_P_SERIAL2  = 6;
   localparam int SMPC_P_SPI      = 7;
   localparam int SMPC_P_I2C      = 8;
   localparam int SMPC_NUM_MOD    = 9;

   // reset values
   localparam logic [8:0] SMPC_GATE_RST  = 9'h1_FF;
   localparam logic [8:0] SMPC_WRST_RST  = 9'h0_00;
   // cycles the wake reset pulse to peripherals is held
   localparam int         SMPC_WAKE_RST_CYC = 2;
   localparam logic [1:0] SMPC_WAKE_RST_CNT = 2'(SMPC_WAKE_RST_CYC);

   // power state of the controller
   typedef enum logic [3:0] {
      SMPC_RUN   = 4'b0001,
      SMPC_LIGHT = 4'b0010,
      SMPC_DEEP  = 4'b0100,
      SMPC_WAKE  = 4'b1000
   } smpc_state_e;

   // configuration bits sampled at the stop instruction
   typedef struct packed {
      logic lowvolt_detect_enable;
      logic lowvolt_detect_in_stop_enable;
      logic stop_depth_select;
      logic stop_instruction_enable;
      logic debug_mode_enable;
      logic osc_in_stop_enable;
      logic converter_async_clock;
   } smpc_cfg_s;

   // power and domain controls sent outward
   typedef struct packed {
      logic regulator_standby;
      logic debug_clk_en;
      logic clkgen_standby;
      logic osc_run;
      logic conv_standby;
      logic core_standby;
      logic logic_power_off;
      logic pin_hold;
      logic kbd_wake_en;
   } smpc_pwr_s;
endpackage
`default_nettype wire

// *** hdl/smpc_resolve.sv ***
// stop-mode resolver: chooses deep or light stop from the configuration
`default_nettype none
module smpc_resolve
   import smpc_pkg::*;
(
   // configuration
   input  wire smpc_cfg_s cfg,
   // resolved choice
   output logic           want_deep,
   output logic           lvd_in_stop,
   output logic           keep_reg
);
   // overrides of deep stop by low-voltage watch or debug
   always_comb begin
      lvd_in_stop = cfg.lowvolt_detect_enable & cfg.lowvolt_detect_in_stop_enable;
      want_deep   = cfg.stop_depth_select & ~lvd_in_stop
                    & ~cfg.debug_mode_enable;
      keep_reg    = lvd_in_stop | cfg.debug_mode_enable;
   end
endmodule
`default_nettype wire

// *** hdl/smpc_top.sv ***
// stop-mode power controller top: stop sequencing, gating and wake resets
`default_nettype none
module smpc_top
   import smpc_pkg::*;
#(
   parameter int NUM_MOD = SMPC_NUM_MOD
)(
   // clock, reset, enable
   input  wire logic                ref_clk,
   input  wire logic                rst_n,
   input  wire logic                clk_en,
   // core side
   input  wire logic                stop_exec,
   input  wire smpc_cfg_s           cfg,
   input  wire logic                wake_event,
   input  wire logic                pin_release_ack,
   // low-voltage detector
   input  wire logic                lowvolt_trip,
   input  wire logic                lowvolt_reset_select,
   // status and resets
   output logic                     deep_stop_wake_flag,
   output logic                     illegal_op_reset,
   output logic                     lowvolt_irq,
   output logic                     lowvolt_reset,
   output logic                     in_stop,
   // power and domain controls
   output smpc_pwr_s                pwr,
   // per-module clock gates and wake resets
   output logic [NUM_MOD-1:0]       periph_clk_en,
   output logic [NUM_MOD-1:0]       periph_wake_rst
);
   typedef struct packed {
      smpc_state_e        st;
      logic               flag;
      logic               ill;
      logic               lv_irq;
      logic               lv_rst;
      logic               lv_seen;
      logic               stp;
      smpc_pwr_s          pw;
      logic [NUM_MOD-1:0] gate;
      logic [NUM_MOD-1:0] wrst;
      logic [1:0]         cnt;
      logic               osc_keep;
      logic               conv_keep;
   } smpc_state_s;

   smpc_state_s r;
   smpc_state_s next_r;
   logic        want_deep;
   logic        lvd_in_stop;
   logic        keep_reg;

   smpc_resolve u_resolve (
      .cfg         (cfg),
      .want_deep   (want_deep),
      .lvd_in_stop (lvd_in_stop),
      .keep_reg    (keep_reg)
   );

   // all-ones mask built at module width
   function automatic logic [NUM_MOD-1:0] all_mods();
      return {NUM_MOD{1'b1}};
   endfunction

   // next-state logic; stop sequencing plus low-voltage events
   always_comb begin
      next_r = r;
      next_r.ill = 1'b0;
      // low-voltage edge gives a one-shot irq or reset
      next_r.lv_seen = lowvolt_trip;
      next_r.lv_irq  = 1'b0;
      next_r.lv_rst  = 1'b0;
      if (lowvolt_trip & ~r.lv_seen & cfg.lowvolt_detect_enable) begin
         next_r.lv_irq = ~lowvolt_reset_select;
         next_r.lv_rst = lowvolt_reset_select;
      end
      // ack clears flag and opens latches; set side lives in run (deep entry), deep and wake states
      if (pin_release_ack & (r.st == SMPC_RUN)) begin
         next_r.flag        = 1'b0;
         next_r.pw.pin_hold = 1'b0;
      end
      case (r.st)
         SMPC_RUN: begin
            next_r.wrst = '0;
            if (stop_exec) begin
               if (!cfg.stop_instruction_enable) begin
                  next_r.ill = 1'b1;
               end else begin
                  next_r.stp = 1'b1;
                  next_r.gate = '0;
                  next_r.pw.debug_clk_en = cfg.debug_mode_enable;
                  next_r.pw.regulator_standby = ~keep_reg;
                  next_r.pw.core_standby = 1'b1;
                  next_r.pw.clkgen_standby = 1'b1;
                  next_r.osc_keep = cfg.osc_in_stop_enable;
                  next_r.conv_keep = cfg.converter_async_clock;
                  if (want_deep) begin
                     next_r.st = SMPC_DEEP;
                     next_r.pw.pin_hold = 1'b1;
                     next_r.pw.logic_power_off = 1'b1;
                     next_r.pw.osc_run = 1'b0;
                     next_r.pw.conv_standby = 1'b1;
                     next_r.pw.kbd_wake_en = 1'b0;
                  end else begin
                     // light stop keeps registers, so pins need no latch
                     next_r.st = SMPC_LIGHT;
                     next_r.pw.osc_run = cfg.osc_in_stop_enable;
                     next_r.pw.conv_standby = ~cfg.converter_async_clock;
                     next_r.pw.kbd_wake_en = 1'b1;
                  end
               end
            end
         end
         SMPC_LIGHT: begin
            if (wake_event) begin
               next_r.st = SMPC_RUN;
               next_r.stp = 1'b0;
               next_r.gate = all_mods();
               next_r.pw = '0;
               next_r.pw.pin_hold = r.pw.pin_hold;
            end
         end
         SMPC_DEEP: begin
            if (wake_event) begin
               next_r.st = SMPC_WAKE;
               next_r.pw.logic_power_off = 1'b0;
               next_r.pw.regulator_standby = 1'b0;
               next_r.wrst = all_mods();
               next_r.cnt = SMPC_WAKE_RST_CNT;
               next_r.flag = 1'b1;
            end
         end
         SMPC_WAKE: begin
            // peripherals held in reset while their clocks restart
            next_r.flag = 1'b1;
            next_r.gate = all_mods();
            if (r.cnt <= 2'h1) begin
               next_r.st = SMPC_RUN;
               next_r.stp = 1'b0;
               next_r.wrst = '0;
               next_r.pw = '0;
               next_r.pw.pin_hold = 1'b1;
               next_r.cnt = '0;
            end else begin
               next_r.cnt = r.cnt - 2'h1;
            end
         end
         default: begin
            next_r.st = SMPC_RUN;
         end
      endcase
   end

   // state register; clock enable freezes everything
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '{st: SMPC_RUN, gate: {NUM_MOD{1'b1}}, default: '0};
      end else if (clk_en) begin
         r <= next_r;
      end
   end

   // outputs straight from flops
   always_comb begin
      deep_stop_wake_flag = r.flag;
      illegal_op_reset    = r.ill;
      lowvolt_irq         = r.lv_irq;
      lowvolt_reset       = r.lv_rst;
      in_stop             = r.stp;
      pwr                 = r.pw;
      periph_clk_en       = r.gate;
      periph_wake_rst     = r.wrst;
   end
endmodule
`default_nettype wire

// *** testbench/smpc_top_assertions.sv ***
// checker for the stop-mode power controller top
`default_nettype none
module smpc_top_assertions
   import smpc_pkg::*;
#(
   parameter int NUM_MOD = SMPC_NUM_MOD
)(
   // block inputs
   input wire logic      ref_clk, rst_n, clk_en, stop_exec, wake_event,
   input wire logic      pin_release_ack, lowvolt_trip, lowvolt_reset_select,
   input wire smpc_cfg_s cfg,
   // block outputs
   input wire logic      deep_stop_wake_flag, illegal_op_reset, lowvolt_irq,
   input wire logic      lowvolt_reset, in_stop,
   input wire smpc_pwr_s pwr,
   input wire logic [NUM_MOD-1:0] periph_clk_en, periph_wake_rst
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // stop taken in run; in_stop low marks run
   sequence s_go;
      clk_en && stop_exec && !in_stop && cfg.stop_instruction_enable;
   endsequence
   sequence s_wake;
      in_stop && pwr.logic_power_off && wake_event && clk_en && !deep_stop_wake_flag;
   endsequence
   property p_ill;
      clk_en && stop_exec && !in_stop && !cfg.stop_instruction_enable |=> illegal_op_reset && !in_stop;
   endproperty
   a_ill: assert property (p_ill) else $error("stop entered while disabled");
   property p_gate;
      s_go |=> in_stop && periph_clk_en == '0;
   endproperty
   a_gate: assert property (p_gate) else $error("clocks run in stop");
   property p_keep;
      s_go ##0 (cfg.debug_mode_enable || cfg.lowvolt_detect_enable
         && cfg.lowvolt_detect_in_stop_enable) |=> !pwr.regulator_standby && !pwr.pin_hold;
   endproperty
   a_keep: assert property (p_keep) else $error("deep stop not overridden");
   property p_dbg;
      s_go ##0 cfg.debug_mode_enable |=> pwr.debug_clk_en;
   endproperty
   a_dbg: assert property (p_dbg) else $error("debug clock halted");
   property p_deep;
      s_go ##0 cfg.stop_depth_select && !cfg.debug_mode_enable && !(cfg.lowvolt_detect_enable
         && cfg.lowvolt_detect_in_stop_enable) |=> pwr.pin_hold && !pwr.osc_run
         && pwr.regulator_standby && !pwr.kbd_wake_en;
   endproperty
   a_deep: assert property (p_deep) else $error("deep stop outputs wrong");
   property p_light;
      s_go ##0 !cfg.stop_depth_select && !cfg.debug_mode_enable |=> pwr.kbd_wake_en
         && !pwr.pin_hold && pwr.osc_run == $past(cfg.osc_in_stop_enable)
         && pwr.conv_standby != $past(cfg.converter_async_clock);
   endproperty
   a_light: assert property (p_light) else $error("light stop outputs wrong");
   property p_wrst;
      s_wake |=> periph_wake_rst == '1 && deep_stop_wake_flag
         ##2 periph_wake_rst == '0 && periph_clk_en == '1 && !in_stop;
   endproperty
   a_wrst: assert property (p_wrst) else $error("deep wake sequence wrong");
   property p_ack;
      deep_stop_wake_flag && !in_stop && pin_release_ack && clk_en
         |=> !deep_stop_wake_flag && !pwr.pin_hold;
   endproperty
   a_ack: assert property (p_ack) else $error("ack did not release");
   property p_lv;
      clk_en && cfg.lowvolt_detect_enable && $rose(lowvolt_trip)
         |-> ##[0:2] (lowvolt_reset_select ? lowvolt_reset : lowvolt_irq);
   endproperty
   a_lv: assert property (p_lv) else $error("low-voltage event missing");
endmodule
bind smpc_top smpc_top_assertions #(.NUM_MOD(NUM_MOD)) u_chk (.*);
`default_nettype wire

// *** testbench/smpc_core_model.sv ***
// core-side model: issues stop instructions and later wake requests
`default_nettype none
module smpc_core_model (
   // from bench and block
   input  wire logic       ref_clk,
   input  wire logic       stop_req,
   input  wire logic [3:0] wake_dly,
   input  wire logic       in_stop,
   // toward block
   output logic            stop_exec,
   output logic            wake_event
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] cnt = 4'h0;
   initial stop_exec = 1'b0;
   initial wake_event = 1'b0;
   // wake after wake_dly stopped cycles, so answers come promptly or slowly
   always @(negedge ref_clk) begin
      stop_exec  <= stop_req && !in_stop;
      cnt        <= in_stop ? cnt + 4'h1 : 4'h0;
      wake_event <= in_stop && cnt >= wake_dly;
   end
endmodule
`default_nettype wire

// *** testbench/smpc_top_tb.sv ***
// self-checking bench for the stop-mode power controller
`default_nettype none
module smpc_top_tb;
   import smpc_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk = 1'b0, rst_n = 1'b0, stop_req = 1'b0, ack = 1'b0, trip = 1'b0, sel = 1'b0;
   logic [3:0] dly = 4'h6;
   logic       ce = 1'b1;
   smpc_cfg_s  c = '0;
   logic       stop_exec, wake_event, flag, ill, lv_irq, lv_rst, in_stop;
   smpc_pwr_s  pwr;
   logic [8:0] gate, wrst;
   int         bad_count = 0, num_checks = 0, cyc = 0, n;
   always #50 ref_clk = ~ref_clk;
   smpc_top u_dut (.ref_clk, .rst_n, .clk_en(ce), .stop_exec, .cfg(c), .wake_event,
      .pin_release_ack(ack), .lowvolt_trip(trip), .lowvolt_reset_select(sel),
      .deep_stop_wake_flag(flag), .illegal_op_reset(ill), .lowvolt_irq(lv_irq),
      .lowvolt_reset(lv_rst), .in_stop, .pwr, .periph_clk_en(gate), .periph_wake_rst(wrst));
   smpc_core_model u_core (.ref_clk, .stop_req, .wake_dly(dly), .in_stop, .stop_exec,
      .wake_event);
   task automatic chk(input string nm, input logic [15:0] s, e);
      num_checks++;
      if (s !== e) begin
         bad_count++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // the model raises stop one cycle after the request; returns after it is taken
   task automatic go(input smpc_cfg_s k);
      @(negedge ref_clk) c = k;
      stop_req <= 1'b1;
      @(negedge ref_clk) stop_req <= 1'b0;
      @(negedge ref_clk);
   endtask
   task automatic run_wait;
      n = 0;
      while (in_stop !== 1'b0 && n < 30) begin @(negedge ref_clk); n++; end
      chk("run", {in_stop, gate}, 10'h1FF);
   endtask
   task automatic t_deep;
      dly = 4'h0;
      go(7'h1A);
      chk("deep", {in_stop, pwr.pin_hold, pwr.logic_power_off, pwr.osc_run, pwr.kbd_wake_en,
         pwr.regulator_standby}, 6'h39);
      chk("gate", gate, 9'h0);
      n = 0;
      while (wrst !== 9'h1FF && n < 20) begin @(negedge ref_clk); n++; end
      chk("wake rst", {flag, wrst}, 10'h3FF);
      run_wait;
      chk("held", {flag, pwr.pin_hold}, 2'h3);
      @(negedge ref_clk) ack = 1'b1;
      @(negedge ref_clk) ack = 1'b0;
      chk("released", {flag, pwr.pin_hold}, 2'h0);
   endtask
   // light stop twice: oscillator kept, then converter on its own clock
   task automatic t_light;
      dly = 4'h6;
      for (int i = 0; i < 2; i++) begin
         go(i ? 7'h09 : 7'h0A);
         chk("light", {in_stop, pwr}, i ? 10'h349 : 10'h379);
         run_wait;
         chk("light wake", {flag, wrst}, 10'h0);
      end
   endtask
   task automatic t_lowvolt;
      logic [1:0] seen;
      for (int i = 0; i < 2; i++) begin
         @(negedge ref_clk) c = 7'h40;
         sel = (i == 1);
         trip = 1'b1;
         seen = 2'h0;
         repeat (4) begin @(negedge ref_clk); seen = seen | {lv_rst, lv_irq}; end
         chk("lowvolt", seen, i ? 2'h2 : 2'h1);
         trip = 1'b0;
      end
   endtask
   initial begin
      repeat (5) @(negedge ref_clk);
      rst_n = 1'b1;
      // clock enable low: a stop request must leave the block in run
      ce = 1'b0;
      go(7'h0A);
      chk("frozen", {ill, in_stop, gate}, 11'h1FF);
      ce = 1'b1;
      go(7'h10);
      chk("illegal", {ill, in_stop}, 2'h2);
      $display("illegal test done");
      t_deep;
      $display("deep test done");
      t_light;
      $display("light test done");
      go(7'h78);
      chk("lvd", {in_stop, pwr.pin_hold, pwr.logic_power_off, pwr.regulator_standby,
         pwr.kbd_wake_en}, 5'h11);
      run_wait;
      go(7'h1C);
      chk("debug", {in_stop, pwr.pin_hold, pwr.debug_clk_en, pwr.regulator_standby, gate},
         13'h1400);
      run_wait;
      $display("override test done");
      t_lowvolt;
      $display("lowvolt test done");
      print_verdict;
   end
   // cycle ceiling against hangs
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 3000) begin
         bad_count++;
         print_verdict;
      end
   end
endmodule
`default_nettype wire
